/* File: core/lcd_function_entry_mode_setup.sv */
// Operation
// - bus width 1: every byte moves once on all eight data lines
// - bus width 0: bytes move as upper then lower nibble on DB7-4
// - glyph height 1: 5x8 cell, 5x7 glyph plus cursor row
// - glyph height 0: 5x12 cell, 5x11 glyph plus cursor row
// - duty field picks one, two or four lines and the duty divisor
// - partition code gives text words 256..160, glyph words 0..96
// - glyph capacity 0/4/8/12 chars at 8 dots, 0/2/4/6 at 12
// - step rule holds separate cursor and origin stepping controls
// - cursor steps after write or read only when that trigger is set
// - origin steps after write or read only when that trigger is set
// - cursor direction 1 decrements, 0 increments, by one
// - origin direction 1 decrements, 0 increments, by one
// - 8-bit status: busy on 7,3, phase low on 6,2, width high
// - 4-bit first status nibble: busy, phase low, width low, height
// - 4-bit second status nibble: busy, phase high, partition bits
// - status reports width bit5, height bit4, partition bits 1-0
// - host-type select high forces status bits 6 and 2 low
module lcd_function_entry_mode_setup
	import lcd_setup_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       strobe_in,
	input  wire logic       io_sel1_in,
	input  wire logic       io_sel2_in,
	input  wire logic       rw_in,
	input  wire logic [7:0] data_in,
	input  wire logic       host_type_in,
	input  wire logic       busy_in,
	output logic      [7:0] data_out,
	output logic      [7:0] data_oe_out,
	output logic            width_8_out,
	output logic            font_8_out,
	output logic      [1:0] duty_out,
	output logic      [1:0] part_out,
	output logic      [7:0] cursor_addr_out,
	output logic      [7:0] origin_addr_out,
	output logic      [3:0] glyph_rows_out,
	output logic      [2:0] lines_out,
	output logic      [5:0] duty_div_out,
	output logic      [8:0] text_words_out,
	output logic      [8:0] glyph_words_out,
	output logic      [3:0] glyph_chars_out
);
	import lcd_setup_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [1:0]  strobe_sync;
	logic [1:0]  host_sync;
	logic [1:0]  busy_sync;
	logic [10:0] bus_s1;
	logic [10:0] bus_s2;
	logic        strobe_prev;

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			strobe_sync <= 2'h0;
			host_sync   <= 2'h0;
			busy_sync   <= 2'h0;
			bus_s1      <= 11'h000;
			bus_s2      <= 11'h000;
			strobe_prev <= 1'b0;
		end
		else
		begin
			strobe_sync <= {strobe_sync[0], strobe_in};
			host_sync   <= {host_sync[0], host_type_in};
			busy_sync   <= {busy_sync[0], busy_in};
			bus_s1      <= {io_sel1_in, io_sel2_in, rw_in, data_in};
			bus_s2      <= bus_s1;
			strobe_prev <= strobe_sync[1];
		end
	end

	// transfer taken on the falling edge of the synchronised strobe
	logic       xfer;
	logic [2:0] sel;
	logic [7:0] bus_data;
	assign xfer     = strobe_prev & ~strobe_sync[1];
	assign sel      = bus_s2[10:8];
	assign bus_data = bus_s2[7:0];

	function automatic logic [7:0] step_addr(input logic [7:0] a, input logic dir);
		step_addr = dir ? 8'(a - ADDR_ONE) : 8'(a + ADDR_ONE);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// settings, nibble assembly and address stepping
	logic          width_8, next_width_8;
	logic          font_8, next_font_8;
	logic [1:0]    duty, next_duty;
	logic [1:0]    part, next_part;
	logic [5:0]    step_rule, next_step_rule;
	logic [7:0]    cursor_addr, next_cursor_addr;
	logic [7:0]    origin_addr, next_origin_addr;
	logic [3:0]    nib_hold, next_nib_hold;
	nibble_phase_t phase, next_phase;
	logic [7:0]    byte_val;
	logic          byte_done;

	always_comb
	begin
		next_width_8     = width_8;
		next_font_8      = font_8;
		next_duty        = duty;
		next_part        = part;
		next_step_rule   = step_rule;
		next_cursor_addr = cursor_addr;
		next_origin_addr = origin_addr;
		next_nib_hold    = nib_hold;
		next_phase       = phase;
		byte_val         = bus_data;
		byte_done        = 1'b0;
		if (xfer)
		begin
			if (width_8)
			begin
				byte_done = 1'b1;
				next_phase = PHASE_HIGH;
			end
			else
			begin
				// only DB7-4 carry data; upper nibble first
				case (phase)
					PHASE_HIGH:
					begin
						next_nib_hold = bus_data[7:4];
						next_phase    = PHASE_LOW;
					end
					PHASE_LOW:
					begin
						byte_val   = {nib_hold, bus_data[7:4]};
						byte_done  = 1'b1;
						next_phase = PHASE_HIGH;
					end
					default: next_phase = PHASE_HIGH;
				endcase
			end
		end
		if (byte_done)
		begin
			case (sel)
				SEL_INSTR_WRITE:
				begin
					if (byte_val[FUNC_PFX_HI:FUNC_PFX_LO] == FUNC_PREFIX)
					begin
						next_width_8 = byte_val[FLD_WIDTH];
						next_font_8  = byte_val[FLD_FONT];
						next_duty    = byte_val[FLD_DUTY_HI:FLD_DUTY_LO];
						next_part    = byte_val[FLD_PART_HI:FLD_PART_LO];
						// new width takes effect from a clean upper nibble
						next_phase   = PHASE_HIGH;
					end
					else if (byte_val[FUNC_PFX_HI:FUNC_PFX_LO] == STEP_PREFIX)
						next_step_rule = byte_val[FLD_CSR_DIR:FLD_DSP_R];
				end
				SEL_DATA_WRITE:
				begin
					if (step_rule[FLD_CSR_W])
						next_cursor_addr = step_addr(cursor_addr, step_rule[FLD_CSR_DIR]);
					if (step_rule[FLD_DSP_W])
						next_origin_addr = step_addr(origin_addr, step_rule[FLD_DSP_DIR]);
				end
				SEL_DATA_READ:
				begin
					if (step_rule[FLD_CSR_R])
						next_cursor_addr = step_addr(cursor_addr, step_rule[FLD_CSR_DIR]);
					if (step_rule[FLD_DSP_R])
						next_origin_addr = step_addr(origin_addr, step_rule[FLD_DSP_DIR]);
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			width_8     <= RST_WIDTH;
			font_8      <= RST_FONT;
			duty        <= RST_DUTY;
			part        <= RST_PART;
			step_rule   <= RST_STEP;
			cursor_addr <= RST_ADDR;
			origin_addr <= RST_ADDR;
			nib_hold    <= 4'h0;
			phase       <= PHASE_HIGH;
		end
		else
		begin
			width_8     <= next_width_8;
			font_8      <= next_font_8;
			duty        <= next_duty;
			part        <= next_part;
			step_rule   <= next_step_rule;
			cursor_addr <= next_cursor_addr;
			origin_addr <= next_origin_addr;
			nib_hold    <= next_nib_hold;
			phase       <= next_phase;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// status read drive; data read bytes belong to the memory path, not here
	logic [7:0] data_q, next_data_q;
	logic [7:0] oe_q, next_oe_q;
	logic       phase_flag;
	logic       rd_sel;

	always_comb
	begin
		rd_sel      = (sel == SEL_STATUS_READ) && bus_s2[8];
		next_data_q = 8'h00;
		next_oe_q   = 8'h00;
		// phase flag marks the second nibble; forced low for the alternate host
		phase_flag  = !width_8 && phase == PHASE_LOW && !host_sync[1];
		if (rd_sel && strobe_sync[1])
		begin
			next_oe_q = width_8 ? 8'hff : 8'hf0;
			if (width_8)
			begin
				next_data_q[ST_BUSY_HI]  = busy_sync[1];
				next_data_q[ST_BUSY_LO]  = busy_sync[1];
				next_data_q[FLD_WIDTH]   = 1'b1;
				next_data_q[FLD_FONT]    = font_8;
				next_data_q[FLD_PART_HI:FLD_PART_LO] = part;
			end
			else if (phase == PHASE_HIGH)
			begin
				next_data_q[ST_BUSY_HI]  = busy_sync[1];
				next_data_q[FLD_WIDTH]   = 1'b0;
				next_data_q[FLD_FONT]    = font_8;
			end
			else
			begin
				next_data_q[ST_BUSY_HI]  = busy_sync[1];
				next_data_q[ST_PHASE_HI] = phase_flag;
				next_data_q[FLD_WIDTH]   = part[1];
				next_data_q[FLD_FONT]    = part[0];
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			data_q <= 8'h00;
			oe_q   <= 8'h00;
		end
		else
		begin
			data_q <= next_data_q;
			oe_q   <= next_oe_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registered outputs
	logic [3:0] g_rows;
	logic [2:0] g_lines;
	logic [5:0] g_div;
	logic [8:0] g_text;
	logic [8:0] g_glyph;
	logic [3:0] g_chars;

	lcd_geometry geometry_u
	(
		.font_8_in       (font_8),
		.duty_in         (duty),
		.part_in         (part),
		.glyph_rows_out  (g_rows),
		.lines_out       (g_lines),
		.duty_div_out    (g_div),
		.text_words_out  (g_text),
		.glyph_words_out (g_glyph),
		.glyph_chars_out (g_chars)
	);

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			glyph_rows_out  <= GLYPH_ROWS_8;
			lines_out       <= LINES_1;
			duty_div_out    <= DUTY_DIV_8;
			text_words_out  <= TEXT_WORDS_BASE;
			glyph_words_out <= 9'h000;
			glyph_chars_out <= 4'h0;
		end
		else
		begin
			glyph_rows_out  <= g_rows;
			lines_out       <= g_lines;
			duty_div_out    <= g_div;
			text_words_out  <= g_text;
			glyph_words_out <= g_glyph;
			glyph_chars_out <= g_chars;
		end
	end

	assign data_out        = data_q;
	assign data_oe_out     = oe_q;
	assign width_8_out     = width_8;
	assign font_8_out      = font_8;
	assign duty_out        = duty;
	assign part_out        = part;
	assign cursor_addr_out = cursor_addr;
	assign origin_addr_out = origin_addr;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	sequence data_byte_write_s;
		byte_done && sel == SEL_DATA_WRITE;
	endsequence

	cursor_write_step_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		data_byte_write_s and (step_rule[FLD_CSR_W] && !step_rule[FLD_CSR_DIR])
		|=> cursor_addr == 8'($past(cursor_addr) + ADDR_ONE))
		else $error("cursor did not increment after write");
	cursor_hold_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!xfer |=> $stable(cursor_addr))
		else $error("cursor moved without a transfer");
	cursor_dec_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		byte_done && sel == SEL_DATA_READ && step_rule[FLD_CSR_R] && step_rule[FLD_CSR_DIR]
		|=> cursor_addr == 8'($past(cursor_addr) - ADDR_ONE))
		else $error("cursor did not decrement after read");
	origin_step_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(data_byte_write_s and !step_rule[FLD_DSP_W]) |=> $stable(origin_addr))
		else $error("origin stepped without write trigger");
	origin_dec_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		data_byte_write_s and (step_rule[FLD_DSP_W] && step_rule[FLD_DSP_DIR])
		|=> origin_addr == 8'($past(origin_addr) - ADDR_ONE))
		else $error("origin did not decrement");
	func_latch_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		byte_done && sel == SEL_INSTR_WRITE && byte_val[FUNC_PFX_HI:FUNC_PFX_LO] == FUNC_PREFIX
		|=> font_8 == $past(byte_val[FLD_FONT])
			&& part == $past(byte_val[FLD_PART_HI:FLD_PART_LO]))
		else $error("function setup not latched");
	status_width_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		oe_q == 8'hff |-> data_q[FLD_WIDTH] && !data_q[ST_PHASE_HI] && !data_q[ST_PHASE_LO])
		else $error("8-bit status flags wrong");
	nibble_lanes_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!width_8 && $stable(width_8) |-> oe_q[3:0] == 4'h0)
		else $error("low lanes driven in 4-bit mode");
	host_type_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		host_sync[1] ##1 host_sync[1] |-> !data_q[ST_PHASE_HI])
		else $error("phase flag high with alternate host");
endmodule

/* File: core/lcd_setup_pkg.sv */
package lcd_setup_pkg;
	// instruction select lines: {io_sel1, io_sel2, rw}
	localparam logic [2:0] SEL_INSTR_WRITE  = 3'h0;
	localparam logic [2:0] SEL_STATUS_READ  = 3'h1;
	localparam logic [2:0] SEL_DATA_WRITE   = 3'h2;
	localparam logic [2:0] SEL_DATA_READ    = 3'h3;
	// opcode prefixes on the upper data lines
	localparam logic [1:0] FUNC_PREFIX      = 2'h3;
	localparam logic [1:0] STEP_PREFIX      = 2'h1;
	localparam int         FUNC_PFX_HI      = 7;
	localparam int         FUNC_PFX_LO      = 6;
	// function setup field positions
	localparam int         FLD_WIDTH        = 5;
	localparam int         FLD_FONT         = 4;
	localparam int         FLD_DUTY_HI      = 3;
	localparam int         FLD_DUTY_LO      = 2;
	localparam int         FLD_PART_HI      = 1;
	localparam int         FLD_PART_LO      = 0;
	// step rule field positions
	localparam int         FLD_CSR_DIR      = 5;
	localparam int         FLD_CSR_W        = 4;
	localparam int         FLD_CSR_R        = 3;
	localparam int         FLD_DSP_DIR      = 2;
	localparam int         FLD_DSP_W        = 1;
	localparam int         FLD_DSP_R        = 0;
	// status byte positions
	localparam int         ST_BUSY_HI       = 7;
	localparam int         ST_PHASE_HI      = 6;
	localparam int         ST_BUSY_LO       = 3;
	localparam int         ST_PHASE_LO      = 2;
	// reset values
	localparam logic       RST_WIDTH        = 1'b1;
	localparam logic       RST_FONT         = 1'b1;
	localparam logic [1:0] RST_DUTY         = 2'h0;
	localparam logic [1:0] RST_PART         = 2'h0;
	localparam logic [5:0] RST_STEP         = 6'h00;
	localparam logic [7:0] RST_ADDR         = 8'h00;
	localparam logic [7:0] ADDR_ONE         = 8'h01;
	// duty encodings
	localparam logic [1:0] DUTY_ONE_LINE    = 2'h0;
	localparam logic [1:0] DUTY_TWO_LINE    = 2'h1;
	localparam logic [1:0] DUTY_FOUR_LINE   = 2'h2;
	// geometry results
	localparam logic [3:0] GLYPH_ROWS_8     = 4'h8;
	localparam logic [3:0] GLYPH_ROWS_12    = 4'hc;
	localparam logic [2:0] LINES_1          = 3'h1;
	localparam logic [2:0] LINES_2          = 3'h2;
	localparam logic [2:0] LINES_4          = 3'h4;
	localparam logic [5:0] DUTY_DIV_8       = 6'h08;
	localparam logic [8:0] TEXT_WORDS_BASE  = 9'h100;
	localparam logic [8:0] GLYPH_WORDS_STEP = 9'h020;
	localparam logic [3:0] CHARS_STEP_8     = 4'h4;
	localparam logic [3:0] CHARS_STEP_12    = 4'h2;

	typedef enum logic [1:0]
	{
		PHASE_HIGH = 2'b01,
		PHASE_LOW  = 2'b10
	} nibble_phase_t;
endpackage

/* File: core/lcd_geometry.sv */
module lcd_geometry
	import lcd_setup_pkg::*;
(
	input  wire logic       font_8_in,
	input  wire logic [1:0] duty_in,
	input  wire logic [1:0] part_in,
	output logic      [3:0] glyph_rows_out,
	output logic      [2:0] lines_out,
	output logic      [5:0] duty_div_out,
	output logic      [8:0] text_words_out,
	output logic      [8:0] glyph_words_out,
	output logic      [3:0] glyph_chars_out
);
	logic [8:0] part_ext;

	always_comb
	begin
		part_ext = {7'h00, part_in};
		// cell height: 5x7 + cursor row, or 5x11 + cursor row
		glyph_rows_out = font_8_in ? GLYPH_ROWS_8 : GLYPH_ROWS_12;
		case (duty_in)
			DUTY_ONE_LINE:  lines_out = LINES_1;
			DUTY_TWO_LINE:  lines_out = LINES_2;
			DUTY_FOUR_LINE: lines_out = LINES_4;
			default:        lines_out = LINES_1;
		endcase
		// duty divisor = lines x cell rows (8,16,32 or 12,24,48)
		// widen both factors first: a 4-bit product would lose 16, 24, 32 and 48
		duty_div_out = 6'(lines_out) * 6'(glyph_rows_out);
		text_words_out  = 9'(TEXT_WORDS_BASE - part_ext * GLYPH_WORDS_STEP);
		glyph_words_out = 9'(part_ext * GLYPH_WORDS_STEP);
		glyph_chars_out = 4'(part_in * (font_8_in ? CHARS_STEP_8 : CHARS_STEP_12));
	end
endmodule

/* File: tb/host_bus_model.sv */
module host_bus_model
	import lcd_setup_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic [7:0] rd_in,
	input  wire logic [7:0] rd_oe_in,
	output logic            strobe_out,
	output logic            sel1_out,
	output logic            sel2_out,
	output logic            rw_out,
	output logic      [7:0] data_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       w8 = 1'b1;
	logic [7:0] oe;

	initial
	begin
		strobe_out = 1'b0;
		{sel1_out, sel2_out, rw_out} = SEL_INSTR_WRITE;
		data_out = 8'h00;
	end

	////////////////////////////////////////////////////////////////
	// select and data set up before strobe and held well past its fall
	task automatic one_xfer(input logic [2:0] s, input logic [7:0] d,
		output logic [7:0] q, output logic [7:0] e);
		@(posedge clk_in);
		{sel1_out, sel2_out, rw_out} <= s;
		data_out <= d;
		repeat (3) @(posedge clk_in);
		strobe_out <= 1'b1;
		repeat (6) @(posedge clk_in);
		@(negedge clk_in);
		q = rd_in;
		e = rd_oe_in;
		@(posedge clk_in);
		strobe_out <= 1'b0;
		repeat (5) @(posedge clk_in);
		// released lines must not keep the stale value
		data_out <= ~d;
	endtask

	task automatic xfer(input logic [2:0] s, input logic [7:0] d, output logic [7:0] q);
		logic [7:0] q1, q2, e1, e2;
		if (w8)
		begin
			one_xfer(s, d, q, oe);
		end
		else
		begin
			// lower lines carry junk, they are unused in this mode
			one_xfer(s, {d[7:4], ~d[7:4]}, q1, e1);
			one_xfer(s, {d[3:0], ~d[3:0]}, q2, e2);
			q = {q1[7:4], q2[7:4]};
			oe = e1 | e2;
		end
	endtask

	task automatic cmd(input logic [2:0] s, input logic [7:0] d, output logic [7:0] q);
		logic [7:0] st;
		int         n;
		n = 0;
		st = 8'h80;
		while (st[7] !== 1'b0 && n < 40)
		begin
			xfer(SEL_STATUS_READ, 8'h00, st);
			n++;
		end
		// a poll that never sees busy clear counts against the run
		test_lcd_function_entry_mode_setup.check({15'h0000, st[7]}, 16'h0000, "busy poll");
		xfer(s, d, q);
		if (s == SEL_INSTR_WRITE && d[7:6] == FUNC_PREFIX)
			w8 = d[FLD_WIDTH];
	endtask
endmodule

/* File: tb/test_lcd_function_entry_mode_setup.sv */
module test_lcd_function_entry_mode_setup
	import lcd_setup_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk, rst_n, host_type, busy, strobe, sel1, sel2, rw, width_8, font_8;
	logic [7:0] hdata, dout, doe, cur_addr, org_addr, q, cur, org;
	logic [1:0] duty, part;
	logic [3:0] rows, chars;
	logic [2:0] lines;
	logic [5:0] div;
	logic [8:0] text_w, glyph_w;
	int         fail_count = 0;
	int         checks_done = 0;

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	lcd_function_entry_mode_setup i_dut (.clk_in(clk), .rst_n_in(rst_n), .strobe_in(strobe),
		.io_sel1_in(sel1), .io_sel2_in(sel2), .rw_in(rw), .data_in(hdata),
		.host_type_in(host_type), .busy_in(busy), .data_out(dout), .data_oe_out(doe),
		.width_8_out(width_8), .font_8_out(font_8), .duty_out(duty), .part_out(part),
		.cursor_addr_out(cur_addr), .origin_addr_out(org_addr), .glyph_rows_out(rows),
		.lines_out(lines), .duty_div_out(div), .text_words_out(text_w),
		.glyph_words_out(glyph_w), .glyph_chars_out(chars));

	host_bus_model i_host (.clk_in(clk), .rd_in(dout), .rd_oe_in(doe), .strobe_out(strobe),
		.sel1_out(sel1), .sel2_out(sel2), .rw_out(rw), .data_out(hdata));

	////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	function automatic logic [7:0] exp_st(input logic b, w, f, ht, input logic [1:0] p);
		return {b, 1'b0, w, f, b, ~w & ~ht, p};
	endfunction

	task automatic status(input logic b, w, f, input logic [1:0] p);
		i_host.xfer(SEL_STATUS_READ, 8'h00, q);
		check(q, exp_st(b, w, f, host_type, p), "status");
		check(i_host.oe, w ? 8'hff : 8'hf0, "drive");
	endtask

	task automatic step(input logic [5:0] m, input logic wr);
		if (wr ? m[FLD_CSR_W] : m[FLD_CSR_R])
			cur = m[FLD_CSR_DIR] ? cur - 8'h01 : cur + 8'h01;
		if (wr ? m[FLD_DSP_W] : m[FLD_DSP_R])
			org = m[FLD_DSP_DIR] ? org - 8'h01 : org + 8'h01;
		check(cur_addr, cur, "cursor");
		check(org_addr, org, "origin");
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (40000) @(posedge clk);
		fail_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		conclude();
	end

	initial
	begin
		rst_n = 1'b0;
		host_type = 1'b0;
		busy = 1'b0;
		cur = 8'h00;
		org = 8'h00;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		check(width_8, 1'b1, "width");
		check(rows, 4'h8, "rows");
		check(text_w, 9'h100, "text");
		check(chars, 4'h0, "chars");
		$display("test reset done");
		// setup precedes every memory transfer
		for (int f = 0; f < 2; f++)
			for (int d = 0; d < 3; d++)
				for (int p = 0; p < 4; p++)
				begin
					i_host.cmd(SEL_INSTR_WRITE, {FUNC_PREFIX, 1'b1, f[0], d[1:0], p[1:0]}, q);
					check(font_8, f[0], "font");
					check({duty, part}, {d[1:0], p[1:0]}, "fields");
					check(rows, f[0] ? 4'h8 : 4'hc, "rows");
					check(lines, 3'h1 << d, "lines");
					check(div, (f[0] ? 6'h08 : 6'h0c) << d, "duty");
					check(text_w, 9'h100 - 9'h020 * 9'(p), "text");
					check(glyph_w, 9'h020 * 9'(p), "glyph");
					check(chars, 4'(p) * (f[0] ? 4'h4 : 4'h2), "chars");
					status(1'b0, 1'b1, f[0], p[1:0]);
				end
		$display("test geometry done");
		for (int c = 0; c < 64; c++)
		begin
			i_host.cmd(SEL_INSTR_WRITE, {STEP_PREFIX, c[5:0]}, q);
			i_host.cmd(SEL_DATA_WRITE, c[7:0], q);
			step(c[5:0], 1'b1);
			i_host.cmd(SEL_DATA_READ, 8'h00, q);
			step(c[5:0], 1'b0);
		end
		$display("test stepping done");
		i_host.cmd(SEL_INSTR_WRITE, 8'hc7, q);
		check({width_8, div}, {1'b0, 6'h18}, "narrow");
		status(1'b0, 1'b0, 1'b0, 2'h3);
		@(posedge clk) host_type <= 1'b1;
		status(1'b0, 1'b0, 1'b0, 2'h3);
		@(posedge clk) host_type <= 1'b0;
		// one step per byte proves nibbles are paired
		i_host.cmd(SEL_INSTR_WRITE, 8'h50, q);
		i_host.cmd(SEL_DATA_WRITE, 8'h5a, q);
		step(6'h10, 1'b1);
		i_host.cmd(SEL_INSTR_WRITE, 8'hf0, q);
		check(width_8, 1'b1, "wide");
		status(1'b0, 1'b1, 1'b1, 2'h0);
		$display("test nibble mode done");
		@(posedge clk) busy <= 1'b1;
		status(1'b1, 1'b1, 1'b1, 2'h0);
		fork
			begin
				repeat (200) @(posedge clk);
				busy <= 1'b0;
			end
		join_none
		i_host.cmd(SEL_INSTR_WRITE, 8'h40, q);
		i_host.cmd(SEL_DATA_WRITE, 8'h11, q);
		step(6'h00, 1'b1);
		status(1'b0, 1'b1, 1'b1, 2'h0);
		$display("test busy done");
		conclude();
	end
endmodule
